// ### hw/shaft_emu_params.svh
`ifndef SHAFT_EMU_PARAMS_SVH
`define SHAFT_EMU_PARAMS_SVH

// ****************************************************
// Frame layout and timing constants
// ****************************************************
`define FRAME_BITS 28
`define REV_BITS 12
`define POS_BITS 16
`define CLK_SYS_NS 100
// Frame-end timeouts in nanoseconds (1.3 us and 10 us)
`define TOUT_SHORT_NS 1300
`define TOUT_LONG_NS 10000
// Least times round up to whole cycles
`define TOUT_SHORT_CYC ((`TOUT_SHORT_NS + `CLK_SYS_NS - 1) / `CLK_SYS_NS)
`define TOUT_LONG_CYC ((`TOUT_LONG_NS + `CLK_SYS_NS - 1) / `CLK_SYS_NS)
`define ZERO_OFFSET_RST 16'h0000

`endif

// ### hw/shaft_emu_pkg.sv
`include "shaft_emu_params.svh"

package shaft_emu_pkg;

  // ****************************************************
  // Types
  // ****************************************************
  // Absolute shaft position: revolution count and angle
  typedef struct packed {
    logic [`REV_BITS-1:0] rev;
    logic [`POS_BITS-1:0] ang;
  } shaft_pos_t;

  // Serial frame state, one bit changing per step from IDLE to SHIFT to WAIT
  typedef enum logic [1:0] {
    FR_IDLE = 2'b00,
    FR_SHIFT = 2'b01,
    FR_WAIT = 2'b11
  } frame_state_t;

  // Whole state of the encoder emulation
  typedef struct packed {
    logic [2:0] clk_sync;
    frame_state_t st;
    logic [`FRAME_BITS-1:0] shreg;
    logic [5:0] bit_cnt;
    logic [9:0] idle_cnt;
    logic data_out;
    logic [`POS_BITS-1:0] ang_prev;
    logic qa;
    logic qb;
    logic qz;
  } emu_state_t;

endpackage

// ### hw/shaft_position_encoder_emulation.sv
// Contract
// RULE1: Both outputs follow the absolute feedback position.
// RULE2: Each serial frame carries 28 data bits.
// RULE3: Revolution count first, twelve bits, MSB first.
// RULE4: Then sixteen angle bits, MSB first.
// RULE5: Setting selects Gray or binary coding.
// RULE6: Setting selects 1.3 us or 10 us timeout.
// RULE7: Controller clocks frames with 600 ns period; the bench reader uses 800 ns.
// RULE8: Count rises for clockwise shaft rotation.
// RULE9: Quadrature A and B plus zero channel.
// RULE10: Zero pulse once per turn, A=B=1.
// RULE11: Stored offset places the zero pulse.
// RULE12: Idle timeout captures fresh position for frame.
module shaft_position_encoder_emulation
  import shaft_emu_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire shaft_pos_t shaft_pos,
  input wire logic frame_code_select,
  input wire logic frame_timeout_select,
  input wire logic [`POS_BITS-1:0] zero_pulse_offset,
  input wire logic incremental_emulation_function,
  input wire logic serial_clk,
  output logic serial_data,
  output logic inc_a,
  output logic inc_b,
  output logic inc_zero
);

  // ****************************************************
  // Constants
  // ****************************************************
  localparam logic [9:0] TOUT_SHORT = 10'(`TOUT_SHORT_CYC);
  localparam logic [9:0] TOUT_LONG = 10'(`TOUT_LONG_CYC);
  localparam logic [5:0] NBITS = 6'(`FRAME_BITS);

  emu_state_t s_q; // Registered state
  emu_state_t s_d; // Next state
  logic [`FRAME_BITS-1:0] frame_bin; // Frame before coding
  logic [`FRAME_BITS-1:0] frame_word; // Frame after coding
  logic [9:0] tout; // Selected timeout in cycles
  logic sclk_fall; // Controller clock falling edge
  logic sclk_rise; // Controller clock rising edge
  logic [1:0] phase; // Quadrature phase from relative angle LSBs
  logic [`POS_BITS-1:0] rel_ang; // Angle relative to zero offset
  logic [1:0] ph_step; // Distance from emitted to target phase
  logic [1:0] ph_next; // Phase emitted on the next clock

  // ****************************************************
  // Combinational next state
  // ****************************************************
  // Frame assembly, timeout choice, shifting and quadrature
  always_comb begin
    s_d = s_q;
    // Angle rises clockwise, so feedback is used as given
    frame_bin = {shaft_pos.rev, shaft_pos.ang}; // RULE1 RULE3 RULE4 RULE8
    if (frame_code_select) begin
      frame_word = frame_bin ^ (frame_bin >> 1); // RULE5
    end else begin
      frame_word = frame_bin; // Binary is the default coding
    end
    tout = frame_timeout_select ? TOUT_LONG : TOUT_SHORT; // RULE6
    // Only bits 1 and 2 are synchronised; bit 0 is the first stage
    sclk_fall = s_q.clk_sync[2] & ~s_q.clk_sync[1];
    sclk_rise = ~s_q.clk_sync[2] & s_q.clk_sync[1];
    s_d.clk_sync = {s_q.clk_sync[1:0], serial_clk};
    unique case (s_q.st)
      FR_IDLE: begin
        // Line idle: hold data high and keep a fresh sample
        s_d.data_out = 1'b1;
        s_d.shreg = frame_word; // RULE12
        if (sclk_fall) begin
          s_d.st = FR_SHIFT;
          s_d.bit_cnt = 6'h00;
        end
      end
      FR_SHIFT: begin
        // Each rising edge presents the next bit, MSB first
        if (sclk_rise) begin
          s_d.data_out = s_q.shreg[`FRAME_BITS-1]; // RULE2
          s_d.shreg = {s_q.shreg[`FRAME_BITS-2:0], 1'b0};
          s_d.bit_cnt = s_q.bit_cnt + 6'h01;
          if (s_q.bit_cnt == NBITS - 6'h01) begin
            s_d.st = FR_WAIT;
          end
        end
        s_d.idle_cnt = 10'h000;
      end
      FR_WAIT: begin
        // Data low until clock rests high for the timeout
        if (sclk_rise) begin
          s_d.data_out = 1'b0;
        end
        if (~s_q.clk_sync[2] || sclk_fall) begin
          s_d.idle_cnt = 10'h000;
        end else if (s_q.idle_cnt >= tout - 10'h001) begin
          s_d.st = FR_IDLE; // RULE12
        end else begin
          s_d.idle_cnt = s_q.idle_cnt + 10'h001;
        end
      end
    endcase
    // Quadrature walks one Gray step per clock toward the target phase,
    // so a jump of the feedback never moves A and B in the same cycle
    rel_ang = shaft_pos.ang - zero_pulse_offset; // RULE11
    phase = rel_ang[1:0];
    ph_step = phase - s_q.ang_prev[1:0];
    ph_next = s_q.ang_prev[1:0];
    if (!incremental_emulation_function) begin
      // Disabled: restart from A0B0 so enabling moves one channel only
      ph_next = 2'b00;
    end else if (ph_step == 2'b11) begin
      // Target one step behind: count down
      ph_next = s_q.ang_prev[1:0] - 2'b01;
    end else if (ph_step != 2'b00) begin
      // Ahead, or half a cycle away: count up, one step at a time
      ph_next = s_q.ang_prev[1:0] + 2'b01;
    end
    // Low two bits keep the phase actually emitted
    s_d.ang_prev = {rel_ang[`POS_BITS-1:2], ph_next};
    if (incremental_emulation_function) begin
      s_d.qa = (ph_next == 2'b01) || (ph_next == 2'b10); // RULE9
      s_d.qb = ph_next[1]; // RULE9
      // A high in 01,10; B high in 10,11: both high only at 10
      s_d.qz = (rel_ang[`POS_BITS-1:2] == '0) && (ph_next == 2'b10); // RULE10
    end else begin
      s_d.qa = 1'b0;
      s_d.qb = 1'b0;
      s_d.qz = 1'b0;
    end
  end

  // ****************************************************
  // State register
  // ****************************************************
  // Synchronous reset to a quiet, idle link
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_q <= '0;
      s_q.data_out <= 1'b1;
      s_q.clk_sync <= 3'h7;
    end else begin
      s_q <= s_d;
    end
  end

  assign serial_data = s_q.data_out;
  assign inc_a = s_q.qa;
  assign inc_b = s_q.qb;
  assign inc_zero = s_q.qz;

  // ****************************************************
  // Assertions
  // ****************************************************
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence frame_start;
    s_q.st == FR_IDLE && sclk_fall;
  endsequence

  AST_START: assert property (frame_start |=> s_q.st == FR_SHIFT) // RULE2
    else $error("frame did not start on clock fall");
  AST_BITCNT: assert property (s_q.st == FR_SHIFT |-> s_q.bit_cnt < NBITS)
    else $error("bit count beyond frame length"); // RULE2
  AST_MSB: assert property (s_q.st == FR_SHIFT && sclk_rise
      |=> serial_data == $past(s_q.shreg[`FRAME_BITS-1])) // RULE3
    else $error("serial bit not taken from frame top");
  AST_IDLE_HIGH: assert property (s_q.st == FR_IDLE |=> serial_data) // RULE12
    else $error("data not high while idle");
  AST_ZERO_AB: assert property (inc_zero |-> inc_a && inc_b) // RULE10
    else $error("zero pulse outside A=B=1");
  // Only while running: switching off drops both channels at once
  AST_QUAD: assert property (incremental_emulation_function
      && $past(incremental_emulation_function) && $changed(inc_a)
      |-> !$changed(inc_b)) // RULE9
    else $error("A and B changed together");
  AST_OFF: assert property (!incremental_emulation_function
      |=> !inc_a && !inc_b && !inc_zero) // RULE9
    else $error("incremental output active when off");
  AST_TOUT: assert property (s_q.st == FR_WAIT |-> s_q.idle_cnt <= TOUT_LONG)
    else $error("timeout counter overran"); // RULE6

  // ****************************************************
  // Frame end, capture, coding and zero pulse checks
  // ****************************************************
  // A rise seen after the last bit
  sequence rise_in_wait;
    s_q.st == FR_WAIT && sclk_rise;
  endsequence

  // Clock has rested high for the whole selected timeout
  sequence tout_reached;
    s_q.st == FR_WAIT && s_q.clk_sync[2] && !sclk_fall
      && s_q.idle_cnt >= tout - 10'h001;
  endsequence

  // A rise during the pause drives the line low
  AST_WAIT_LOW: assert property (rise_in_wait |=> !serial_data) // RULE2
    else $error("data not low after last bit");
  // Selected timeout ends the pause
  AST_TOUT_END: assert property (tout_reached |=> s_q.st == FR_IDLE) // RULE6
    else $error("frame did not end after timeout");
  // A pause never ends before the short timeout has run
  AST_TOUT_MIN: assert property (s_q.st == FR_WAIT
      && s_q.idle_cnt < TOUT_SHORT - 10'h001 |=> s_q.st != FR_IDLE) // RULE6
    else $error("frame ended before timeout");
  // Idle keeps taking the coded position for the next frame
  AST_CAPTURE: assert property (s_q.st == FR_IDLE
      |=> s_q.shreg == $past(frame_word)) // RULE12
    else $error("idle frame not refreshed");
  // Gray coding touches the word only when selected
  AST_BINARY: assert property (!frame_code_select
      |-> frame_word == frame_bin) // RULE5
    else $error("binary frame was recoded");
  // Zero pulse only in the first quadrature cycle after the offset
  AST_ZERO_POS: assert property (inc_zero
      |-> $past(rel_ang[`POS_BITS-1:2]) == '0) // RULE10 RULE11
    else $error("zero pulse away from offset");

endmodule

// ### verif/frame_reader.sv
module frame_reader (
  output logic serial_clk,
  input wire logic serial_data
);
  timeunit 1ns;
  timeprecision 100ps;
  // ********
  // Far side
  // ********
  localparam int HALF_NS = 400; // Link clock half period in the bench
  initial serial_clk = 1'b1; // Clock rests high outside frames
  // One frame: a fall, then 28 bit rises and a closing rise; each bit is taken before next rise
  task automatic read_frame(output logic [27:0] word);
    #37; // Keeps the link clock out of phase with the system clock
    serial_clk = 1'b0;
    #HALF_NS;
    for (int i = 27; i >= 0; i--) begin
      serial_clk = 1'b1;
      #HALF_NS serial_clk = 1'b0;
      #(HALF_NS - 10) word[i] = serial_data;
      #10;
    end
    serial_clk = 1'b1; // Closing rise; clock then rests high
  endtask
endmodule

// ### verif/test_shaft_position_encoder_emulation.sv
module test_shaft_position_encoder_emulation;
  timeunit 1ns;
  timeprecision 100ps;
  import shaft_emu_pkg::*;
  // *******
  // Harness
  // *******
  typedef struct {
    shaft_pos_t pos;
    logic gray;
    logic tout;
    logic [15:0] off;
    logic [2:0] abz;
  } row_t;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  shaft_pos_t shaft_pos = '0;
  logic gray = 1'b0;
  logic tout = 1'b0;
  logic [15:0] off = 16'h0000;
  logic inc_en = 1'b1;
  logic serial_clk, serial_data, inc_a, inc_b, inc_zero;
  logic [27:0] word, exp_w;
  int n_fail = 0;
  int compares = 0;
  // Rows: position, coding, timeout, zero offset, expected A/B/Z
  row_t rows[4] = '{
    '{{12'h801, 16'h8001}, 1'b0, 1'b0, 16'h0000, 3'b100},
    '{{12'h3a5, 16'h0007}, 1'b1, 1'b1, 16'h0005, 3'b111},
    '{{12'hfff, 16'h0000}, 1'b0, 1'b1, 16'h0000, 3'b000},
    '{{12'h000, 16'h1006}, 1'b1, 1'b0, 16'h0004, 3'b110}};
  initial forever #50 clk_sys = ~clk_sys;
  shaft_position_encoder_emulation DUT (.clk_sys(clk_sys), .rst(rst),
    .shaft_pos(shaft_pos), .frame_code_select(gray),
    .frame_timeout_select(tout), .zero_pulse_offset(off),
    .incremental_emulation_function(inc_en), .serial_clk(serial_clk),
    .serial_data(serial_data), .inc_a(inc_a), .inc_b(inc_b),
    .inc_zero(inc_zero));
  frame_reader PM (.serial_clk(serial_clk), .serial_data(serial_data));
  task automatic chk(string what, logic [27:0] seen, logic [27:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic end_of_test();
    if (n_fail == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    cyc(8);
    rst = 1'b0;
    foreach (rows[r]) begin
      shaft_pos = rows[r].pos;
      gray = rows[r].gray;
      tout = rows[r].tout;
      off = rows[r].off;
      cyc(20);
      chk("abz", 28'({inc_a, inc_b, inc_zero}), 28'(rows[r].abz));
      exp_w = rows[r].pos;
      if (gray) exp_w = exp_w ^ (exp_w >> 1);
      PM.read_frame(word);
      chk("frame", word, exp_w);
      cyc(tout ? 88 : 8);
      chk("held low", 28'(serial_data), 28'h0);
      cyc(tout ? 25 : 16);
      chk("idle high", 28'(serial_data), 28'h1);
    end
    // Next frame must carry the position captured after the idle time
    shaft_pos = '{12'h123, 16'h4567};
    gray = 1'b0;
    cyc(20);
    PM.read_frame(word);
    chk("fresh frame", word, 28'h1234567);
    cyc(20);
    inc_en = 1'b0;
    off = 16'h4565;
    cyc(4);
    chk("abz off", 28'({inc_a, inc_b, inc_zero}), 28'h0);
    rst = 1'b1;
    cyc(2);
    chk("reset data", 28'(serial_data), 28'h1);
    chk("reset abz", 28'({inc_a, inc_b, inc_zero}), 28'h0);
    rst = 1'b0;
    cyc(20);
    PM.read_frame(word);
    chk("frame after reset", word, 28'h1234567);
    cyc(20);
    end_of_test();
  end
endmodule
